/* File: rtl/bfr_fifo_dev.sv */
`timescale 1ns/1ns
`include "bfr_params.svh"
module bfr_fifo_dev #(
	parameter int DATA_W = `BFR_DATA_W,
	parameter int DEPTH = `BFR_DEPTH,
	parameter int ALMOST_FULL_LVL = `BFR_ALMOST_FULL_LVL,
	parameter int ALMOST_EMPTY_LVL = `BFR_ALMOST_EMPTY_LVL,
	parameter logic [2:0] WR_CS_MATCH = `BFR_WR_CS_MATCH,
	parameter logic [2:0] RD_CS_MATCH = `BFR_RD_CS_MATCH
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	bfr_if.dev port,
	output logic write_refused,
	output logic read_refused,
	output logic [$clog2(DEPTH):0] fill_level
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_L = (AW+1)'(DEPTH);
	localparam logic [AW:0] AF_L = (AW+1)'(ALMOST_FULL_LVL);
	localparam logic [AW:0] AE_L = (AW+1)'(ALMOST_EMPTY_LVL);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic cs_hit(
		input logic [2:0] match,
		input logic [2:0] word
	);
		cs_hit = (word == match);
	endfunction : cs_hit

	function automatic logic [AW:0] used_of(
		input logic [AW:0] wp,
		input logic [AW:0] rp
	);
		used_of = wp - rp;
	endfunction : used_of

	// ----------------------------------------
	// Storage and pointers
	// ----------------------------------------
	logic [DATA_W-1:0] mem [0:DEPTH-1];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] wr_ptr_next;
	logic [AW:0] rd_ptr_reg;
	logic [AW:0] rd_ptr_next;
	logic [DATA_W-1:0] rd_stage_reg;
	logic rd_stage_valid_reg;
	logic [DATA_W-1:0] rd_out_reg;
	logic rd_out_valid_reg;
	logic wr_refused_reg;
	logic rd_refused_reg;
	logic wr_refused_next;
	logic rd_refused_next;
	logic [DATA_W-1:0] rd_stage_next;
	logic rd_stage_valid_next;
	logic [DATA_W-1:0] rd_out_next;
	logic rd_out_valid_next;

	// ----------------------------------------
	// Reset combining
	// ----------------------------------------
	// Global set/reset is never gated in FIFO mode; it joins the
	// memory reset with no clock involvement.
	wire core_clear = ~rstn | port.mem_reset | port.global_set_reset; // RQ2 RQ6 RQ8 RQ9
	// Pointer rewind has its own asynchronous path.
	wire rdptr_clear = core_clear | port.read_pointer_reset; // RQ8 RQ14

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// The select high bits carry the outside full/empty input.
	wire [2:0] wr_cs_word = {port.write_select_high_bit, port.write_chip_select}; // RQ12
	wire [2:0] rd_cs_word = {port.read_select_high_bit, port.read_chip_select}; // RQ12
	wire wr_sel = cs_hit(WR_CS_MATCH, wr_cs_word); // RQ11
	wire rd_sel = cs_hit(RD_CS_MATCH, rd_cs_word); // RQ11
	wire [AW:0] used = used_of(wr_ptr_reg, rd_ptr_reg);
	wire is_full = (used == DEPTH_L); // RQ16
	wire is_empty = (used == '0); // RQ16
	wire is_almost_full = (used >= AF_L); // RQ13
	wire is_almost_empty = (used <= AE_L); // RQ13
	wire wr_try = clk_en & port.write_enable & wr_sel; // RQ15
	wire rd_try = clk_en & port.read_enable & rd_sel; // RQ15
	wire wr_do = wr_try & ~is_full; // RQ16
	wire rd_do = rd_try & ~is_empty; // RQ16
	wire [AW-1:0] wr_addr = wr_ptr_reg[AW-1:0];
	wire [AW-1:0] rd_addr = rd_ptr_reg[AW-1:0];

	assign wr_ptr_next = wr_do ? wr_ptr_reg + (AW+1)'(1) : wr_ptr_reg;
	assign rd_ptr_next = rd_do ? rd_ptr_reg + (AW+1)'(1) : rd_ptr_reg;

	// ----------------------------------------
	// Write side next values
	// ----------------------------------------
	// Refusals are single pulses, never sticky, so no set/clear
	// race can arise against a later access.
	assign wr_refused_next = wr_try & is_full; // RQ16

	// ----------------------------------------
	// Read side next values
	// ----------------------------------------
	assign rd_refused_next = rd_try & is_empty; // RQ16
	// Stage keeps its word when no read is taken.
	assign rd_stage_next = rd_do ? mem[rd_addr] : rd_stage_reg;
	assign rd_stage_valid_next = rd_do;
	// With the output read enable low the word is held and gets
	// no valid pulse; a word staged meanwhile is dropped.
	assign rd_out_next = port.output_read_enable ? rd_stage_reg : rd_out_reg; // RQ11
	assign rd_out_valid_next = port.output_read_enable & rd_stage_valid_reg; // RQ11

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Flags follow the pointer flops directly so the user sees a
	// new level in the cycle after the access.
	assign port.full_flag = is_full; // RQ13
	assign port.empty_flag = is_empty; // RQ13
	assign port.almost_full_flag = is_almost_full; // RQ13
	assign port.almost_empty_flag = is_almost_empty; // RQ13
	assign port.read_data = rd_out_reg;
	assign port.read_data_valid = rd_out_valid_reg;
	assign write_refused = wr_refused_reg;
	assign read_refused = rd_refused_reg;
	assign fill_level = used;

	// ----------------------------------------
	// Write port
	// ----------------------------------------
	// One clock serves both ports here; the port logic is split so
	// a second clock could be fed to the read side alone.
	always_ff @(posedge sys_clk or posedge core_clear) begin // RQ10 RQ15
		if (core_clear) begin
			wr_ptr_reg <= '0;
			wr_refused_reg <= 1'b0;
		end else if (clk_en) begin
			wr_ptr_reg <= wr_ptr_next;
			wr_refused_reg <= wr_refused_next;
		end
	end

	// Array has no reset: contents survive, only pointers move.
	// Write strobe already carries the clock enable.
	always_ff @(posedge sys_clk) begin
		if (wr_do) begin
			mem[wr_addr] <= port.write_data;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rdptr_clear) begin // RQ10 RQ14
		if (rdptr_clear) begin
			rd_ptr_reg <= '0;
		end else if (clk_en) begin
			rd_ptr_reg <= rd_ptr_next;
		end
	end

	always_ff @(posedge sys_clk or posedge core_clear) begin
		if (core_clear) begin
			rd_stage_reg <= '0;
			rd_stage_valid_reg <= 1'b0;
			rd_refused_reg <= 1'b0;
		end else if (clk_en) begin
			rd_stage_reg <= rd_stage_next;
			rd_stage_valid_reg <= rd_stage_valid_next;
			rd_refused_reg <= rd_refused_next;
		end
	end

	// Output register loads only while the output read enable is high,
	// so the user can hold a word on the bus while reads continue.
	always_ff @(posedge sys_clk or posedge core_clear) begin // RQ11
		if (core_clear) begin
			rd_out_reg <= '0;
			rd_out_valid_reg <= 1'b0;
		end else if (clk_en) begin
			rd_out_reg <= rd_out_next;
			rd_out_valid_reg <= rd_out_valid_next;
		end
	end

	// ----------------------------------------
	// Pointer scheme
	// ----------------------------------------
	// Pointers carry one wrap bit above the address, so full and
	// empty differ without a spare entry.
	// Limitation: a rewind replays old words only while the write
	// pointer has not wrapped past them; after a wrap the level
	// seen after a rewind no longer matches the words held.

	// ----------------------------------------
	// Notes on reset use
	// ----------------------------------------
	// Clearing mid-access is safe only when the user has kept the
	// enables low around it; this end trusts that and does not
	// watch for a violation.
	// RQ1 RQ5 RQ7
	// A word read in the same cycle as a pointer rewind comes from the first entry and is read again:
	// the rewind wins over the increment.
	// RQ14

endmodule : bfr_fifo_dev

/* File: include/bfr_params.svh */
`ifndef BFR_PARAMS_SVH
`define BFR_PARAMS_SVH
// Summary of operation
// [RQ1] Enables low one cycle around asynchronous reset
// [RQ2] Global set/reset acts without any clock
// [RQ3] Reset with enables on needs steady clocks
// [RQ4] Preloaded memory: global reset released early
// [RQ5] Same reset sequencing for RAM, ROM, FIFO
// [RQ6] FIFO: global reset enabled, enables gate sequence
// [RQ7] Pointer reset against read, memory against both
// [RQ8] Memory and pointer resets act asynchronously
// [RQ9] Synchronous reset without global: no restriction
// [RQ10] Separate write and read port clocks; one sys_clk drives both ports here
// [RQ11] Per-port chip select, output read enable
// [RQ12] Full/empty inputs are chip select bit two
// [RQ13] Full, almost full, empty, almost empty flags
// [RQ14] Read pointer reset rewinds read pointer only
// [RQ15] Rising edge sampling, controls active high
// [RQ16] Writes when full, reads when empty ignored

// ----------------------------------------
// Geometry and flag levels
// ----------------------------------------
`define BFR_DATA_W 9
`define BFR_DEPTH 1024
`define BFR_ALMOST_FULL_LVL 1020
`define BFR_ALMOST_EMPTY_LVL 4

// ----------------------------------------
// Chip select decode, {select high bit, cs[1:0]}
// ----------------------------------------
`define BFR_WR_CS_MATCH 3'h1
`define BFR_RD_CS_MATCH 3'h1

// ----------------------------------------
// Reset sequencing, in sys_clk cycles
// ----------------------------------------
`define BFR_QUIET_CYC 1
`define BFR_RST_HOLD_CYC 2
`define BFR_SETTLE_CYC 1
`endif

/* File: include/bfr_pkg.sv */
package bfr_pkg;
	typedef enum logic [3:0] {
		BFR_SEQ_IDLE = 4'h1,
		BFR_SEQ_QUIET = 4'h2,
		BFR_SEQ_HOLD = 4'h4,
		BFR_SEQ_SETTLE = 4'h8
	} bfr_seq_e;

	typedef enum logic [2:0] {
		BFR_RST_NONE = 3'h1,
		BFR_RST_MEM = 3'h2,
		BFR_RST_RDPTR = 3'h4
	} bfr_rst_kind_e;
endpackage : bfr_pkg

/* File: include/bfr_if.sv */
`timescale 1ns/1ns
`include "bfr_params.svh"
interface bfr_if #(
	parameter int DATA_W = `BFR_DATA_W
);
	logic write_enable;
	logic [1:0] write_chip_select;
	logic write_select_high_bit;
	logic [DATA_W-1:0] write_data;
	logic read_enable;
	logic [1:0] read_chip_select;
	logic read_select_high_bit;
	logic output_read_enable;
	logic mem_reset;
	logic read_pointer_reset;
	logic global_set_reset;
	logic [DATA_W-1:0] read_data;
	logic read_data_valid;
	logic full_flag;
	logic almost_full_flag;
	logic empty_flag;
	logic almost_empty_flag;

	modport dev (
		input write_enable, write_chip_select, write_select_high_bit, write_data,
		input read_enable, read_chip_select, read_select_high_bit, output_read_enable,
		input mem_reset, read_pointer_reset, global_set_reset,
		output read_data, read_data_valid,
		output full_flag, almost_full_flag, empty_flag, almost_empty_flag
	);

	modport usr (
		output write_enable, write_chip_select, write_select_high_bit, write_data,
		output read_enable, read_chip_select, read_select_high_bit, output_read_enable,
		output mem_reset, read_pointer_reset, global_set_reset,
		input read_data, read_data_valid,
		input full_flag, almost_full_flag, empty_flag, almost_empty_flag
	);
endinterface : bfr_if

/* File: rtl/bfr_fifo_usr.sv */
`timescale 1ns/1ns
`include "bfr_params.svh"
module bfr_fifo_usr #(
	parameter int DATA_W = `BFR_DATA_W,
	parameter int HOLD_CYC = `BFR_RST_HOLD_CYC,
	parameter logic [2:0] WR_CS_MATCH = `BFR_WR_CS_MATCH,
	parameter logic [2:0] RD_CS_MATCH = `BFR_RD_CS_MATCH
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	bfr_if.usr port,
	input wire logic usr_wr_valid,
	input wire logic [DATA_W-1:0] usr_wr_data,
	output logic usr_wr_ready,
	input wire logic usr_rd_valid,
	output logic usr_rd_ready,
	output logic [DATA_W-1:0] usr_rd_data,
	output logic usr_rd_data_valid,
	input wire logic usr_mem_reset_req,
	input wire logic usr_rdptr_reset_req,
	output logic usr_seq_busy
);
	localparam logic [7:0] HOLD_L = 8'(HOLD_CYC);

	bfr_pkg::bfr_seq_e seq_reg;
	bfr_pkg::bfr_seq_e seq_next;
	bfr_pkg::bfr_rst_kind_e kind_reg;
	logic [7:0] cnt_reg;
	logic [DATA_W-1:0] rd_data_reg;
	logic rd_valid_reg;

	// ----------------------------------------
	// Access gating
	// ----------------------------------------
	// Enables stay low through the quiet, hold and settle cycles.
	wire idle = (seq_reg == bfr_pkg::BFR_SEQ_IDLE); // RQ1 RQ6 RQ7
	wire start = idle & (usr_mem_reset_req | usr_rdptr_reset_req);
	assign usr_wr_ready = idle & ~start & ~port.full_flag;
	assign usr_rd_ready = idle & ~start & ~port.empty_flag;
	assign port.write_enable = clk_en & usr_wr_valid & usr_wr_ready; // RQ1 RQ7
	assign port.read_enable = clk_en & usr_rd_valid & usr_rd_ready; // RQ1 RQ7
	assign port.write_data = usr_wr_data;
	// Outside full/empty inputs unused: tied to the decode value.
	assign port.write_chip_select = WR_CS_MATCH[1:0]; // RQ12
	assign port.write_select_high_bit = WR_CS_MATCH[2]; // RQ12
	assign port.read_chip_select = RD_CS_MATCH[1:0]; // RQ12
	assign port.read_select_high_bit = RD_CS_MATCH[2]; // RQ12
	assign port.output_read_enable = 1'b1;
	// Held low always, so preloaded contents are never disturbed.
	assign port.global_set_reset = 1'b0; // RQ4 RQ9
	wire holding = (seq_reg == bfr_pkg::BFR_SEQ_HOLD);
	assign port.mem_reset = holding & (kind_reg == bfr_pkg::BFR_RST_MEM); // RQ5 RQ7
	assign port.read_pointer_reset = holding & (kind_reg == bfr_pkg::BFR_RST_RDPTR); // RQ7
	assign usr_seq_busy = ~idle;
	assign usr_rd_data = rd_data_reg;
	assign usr_rd_data_valid = rd_valid_reg;

	// ----------------------------------------
	// Reset sequencer
	// ----------------------------------------
	// Clocks can stop here (clk_en low), so the quiet-cycle form is used
	// instead of relying on steady clocks.
	always_comb begin // RQ1 RQ3
		seq_next = seq_reg;
		case (seq_reg)
			bfr_pkg::BFR_SEQ_IDLE: begin
				if (start) begin
					seq_next = bfr_pkg::BFR_SEQ_QUIET;
				end
			end
			bfr_pkg::BFR_SEQ_QUIET: begin
				seq_next = bfr_pkg::BFR_SEQ_HOLD;
			end
			bfr_pkg::BFR_SEQ_HOLD: begin
				if (cnt_reg == HOLD_L - 8'h01) begin
					seq_next = bfr_pkg::BFR_SEQ_SETTLE;
				end
			end
			bfr_pkg::BFR_SEQ_SETTLE: begin
				seq_next = bfr_pkg::BFR_SEQ_IDLE;
			end
			default: begin
				seq_next = bfr_pkg::BFR_SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			seq_reg <= bfr_pkg::BFR_SEQ_IDLE;
			kind_reg <= bfr_pkg::BFR_RST_NONE;
			cnt_reg <= 8'h00;
		end else if (clk_en) begin
			seq_reg <= seq_next;
			cnt_reg <= holding ? cnt_reg + 8'h01 : 8'h00;
			if (start) begin
				kind_reg <= usr_mem_reset_req ? bfr_pkg::BFR_RST_MEM
					: bfr_pkg::BFR_RST_RDPTR;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data_reg <= '0;
			rd_valid_reg <= 1'b0;
		end else if (clk_en) begin
			rd_valid_reg <= port.read_data_valid;
			if (port.read_data_valid) begin
				rd_data_reg <= port.read_data;
			end
		end
	end

endmodule : bfr_fifo_usr

/* File: verif/bfr_fifo_sva.sv */
`timescale 1ns/1ns
module bfr_fifo_sva (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic write_enable,
	input wire logic read_enable,
	input wire logic output_read_enable,
	input wire logic mem_reset,
	input wire logic read_pointer_reset,
	input wire logic global_set_reset,
	input wire logic read_data_valid,
	input wire logic full_flag,
	input wire logic almost_full_flag,
	input wire logic empty_flag,
	input wire logic almost_empty_flag
);
	// ----------------------------------------
	// Interface rules, both ends
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	wire rd_take = clk_en && read_enable && !empty_flag;
	wire any_rst = mem_reset || read_pointer_reset;
	property p_rst_empty; mem_reset || global_set_reset |-> empty_flag && !full_flag; endproperty
	a_rst_empty: assert property (p_rst_empty) else $error("reset left flags");
	property p_rst_quiet; any_rst |-> !write_enable && !read_enable; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("enable during reset");
	property p_rst_pre; $rose(mem_reset) |-> !$past(write_enable) && !$past(read_enable); endproperty
	a_rst_pre: assert property (p_rst_pre) else $error("no quiet cycle before reset");
	property p_rst_post; $fell(mem_reset) || $fell(read_pointer_reset) |-> !write_enable && !read_enable; endproperty
	a_rst_post: assert property (p_rst_post) else $error("no quiet cycle after reset");
	property p_rst_len; $rose(mem_reset) |-> mem_reset[*2] ##1 !mem_reset; endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset pulse length");
	property p_gsr_off; !global_set_reset; endproperty
	a_gsr_off: assert property (p_gsr_off) else $error("global reset used");
	property p_rd_lat; rd_take ##1 output_read_enable ##1 output_read_enable |-> read_data_valid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read word missing");
	property p_rd_none; clk_en && empty_flag ##1 clk_en |-> ##1 !read_data_valid; endproperty
	a_rd_none: assert property (p_rd_none) else $error("read while empty gave data");
	property p_wr_first; clk_en && write_enable && empty_flag && !read_enable |=> !empty_flag; endproperty
	a_wr_first: assert property (p_wr_first) else $error("write not taken");
	property p_full_hold; full_flag && !read_enable |=> full_flag || mem_reset; endproperty
	a_full_hold: assert property (p_full_hold) else $error("full dropped");
	property p_af; full_flag |-> almost_full_flag; endproperty
	a_af: assert property (p_af) else $error("full without almost full");
	property p_ae; empty_flag |-> almost_empty_flag; endproperty
	a_ae: assert property (p_ae) else $error("empty without almost empty");
endmodule : bfr_fifo_sva

/* File: verif/block_ram_fifo_reset_control_test.sv */
`timescale 1ns/1ns
module block_ram_fifo_reset_control_test;
	typedef struct packed {logic [8:0] din; logic ae;} bfr_row_s;
	bfr_row_s rows [6] = '{'{9'h000, 1'h1}, '{9'h1FF, 1'h1}, '{9'h155, 1'h1},
		'{9'h0AA, 1'h1}, '{9'h101, 1'h0}, '{9'h0FE, 1'h0}};
	logic sys_clk = 1'h0, rstn = 1'h0, clk_en = 1'h1, wr_valid = 1'h0, rd_valid = 1'h0;
	logic mem_req = 1'h0, ptr_req = 1'h0, wr_ready, rd_ready, rd_dv, busy, wr_ref, rd_ref;
	logic [8:0] wr_data = 9'h000, rd_data;
	logic [10:0] fill;
	int bad_count = 0, samples_checked = 0;
	bfr_if port_if ();
	bfr_fifo_dev bfr_fifo_dev_inst (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
		.port(port_if.dev), .write_refused(wr_ref), .read_refused(rd_ref), .fill_level(fill));
	bfr_fifo_usr bfr_fifo_usr_inst (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
		.port(port_if.usr), .usr_wr_valid(wr_valid), .usr_wr_data(wr_data),
		.usr_wr_ready(wr_ready), .usr_rd_valid(rd_valid), .usr_rd_ready(rd_ready),
		.usr_rd_data(rd_data), .usr_rd_data_valid(rd_dv), .usr_mem_reset_req(mem_req),
		.usr_rdptr_reset_req(ptr_req), .usr_seq_busy(busy));
	bfr_fifo_sva bfr_fifo_sva_inst (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
		.write_enable(port_if.write_enable), .read_enable(port_if.read_enable),
		.output_read_enable(port_if.output_read_enable), .mem_reset(port_if.mem_reset),
		.read_pointer_reset(port_if.read_pointer_reset),
		.global_set_reset(port_if.global_set_reset), .read_data_valid(port_if.read_data_valid),
		.full_flag(port_if.full_flag), .almost_full_flag(port_if.almost_full_flag),
		.empty_flag(port_if.empty_flag), .almost_empty_flag(port_if.almost_empty_flag));
	always #2 sys_clk = ~sys_clk;
	// ----------------------------------------
	// Checking and handshake helpers
	// ----------------------------------------
	task automatic conclude();
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic good, input string what);
		samples_checked++;
		if (good !== 1'h1) begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask : chk
	// A stalled handshake ends the run rather than hanging it
	task automatic need(input logic good, input string what);
		chk(good, what);
		if (good !== 1'h1) conclude();
	endtask : need
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask : tick
	// Caller lowers wr_valid, so back-to-back writes never toggle it in one step
	task automatic wr(input logic [8:0] d, input int n, output logic acc);
		logic rdy;
		wr_valid = 1'h1;
		wr_data = d;
		acc = 1'h0;
		repeat (n) if (!acc) begin
			rdy = wr_ready;
			tick();
			acc = rdy;
		end
	endtask : wr
	task automatic rd(input logic [8:0] e);
		logic rdy, got;
		rd_valid = 1'h1;
		got = 1'h0;
		repeat (20) if (!got) begin
			rdy = rd_ready;
			tick();
			got = rdy;
		end
		rd_valid = 1'h0;
		need(got, "read stalled");
		got = 1'h0;
		repeat (8) if (!got) begin
			tick();
			got = rd_dv;
		end
		need(got, "read word missing");
		chk(rd_data === e, "read word");
	endtask : rd
	task automatic seq(input logic mem);
		int k;
		mem_req = mem;
		ptr_req = !mem;
		for (k = 0; k < 20 && busy !== 1'h1; k++) tick();
		mem_req = 1'h0;
		ptr_req = 1'h0;
		need(busy, "no reset sequence");
		for (k = 0; k < 20 && busy !== 1'h0; k++) tick();
		need(busy === 1'h0, "sequence stuck");
	endtask : seq
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		int i;
		logic acc;
		repeat (5) @(posedge sys_clk);
		chk(port_if.empty_flag === 1'h1 && port_if.full_flag === 1'h0, "reset flags");
		#1 rstn = 1'h1;
		for (i = 0; i < 6; i++) begin
			wr(rows[i].din, 20, acc);
			need(acc, "write stalled");
			chk(fill === 11'(i + 1) && port_if.almost_empty_flag === rows[i].ae, "fill");
		end
		wr_valid = 1'h0;
		for (i = 0; i < 6; i++) rd(rows[i].din);
		wr(9'h0AA, 20, acc);
		wr_valid = 1'h0;
		seq(1'h1);
		chk(fill === 11'h000 && port_if.empty_flag === 1'h1 && rd_ready === 1'h0, "clear");
		rd_valid = 1'h1;
		repeat (3) tick();
		rd_valid = 1'h0;
		chk(fill === 11'h000 && rd_dv === 1'h0 && rd_ref === 1'h0, "read while empty");
		for (i = 0; i < 1024; i++) begin
			wr(i[8:0], 20, acc);
			need(acc, "write stalled");
			if (i >= 1018 && i <= 1019) chk(port_if.almost_full_flag === (i == 1019), "af");
		end
		chk(port_if.full_flag === 1'h1 && wr_ready === 1'h0, "full");
		wr(9'h1FF, 4, acc);
		wr_valid = 1'h0;
		chk(acc === 1'h0 && fill === 11'h400 && wr_ref === 1'h0, "write while full");
		rd(9'h000);
		rd(9'h001);
		seq(1'h0);
		chk(fill === 11'h400 && port_if.full_flag === 1'h1, "pointer rewind");
		rd(9'h000);
		// Clock enable low: level, sequencer and output pulse all hold
		clk_en = 1'h0;
		wr_valid = 1'h1;
		mem_req = 1'h1;
		repeat (3) tick();
		chk(fill === 11'h3FF && busy === 1'h0 && rd_dv === 1'h1, "frozen");
		wr_valid = 1'h0;
		mem_req = 1'h0;
		clk_en = 1'h1;
		rstn = 1'h0;
		tick();
		chk(port_if.empty_flag === 1'h1 && fill === 11'h000 && busy === 1'h0 && rd_dv === 1'h0,
			"mid reset");
		rstn = 1'h1;
		tick();
		chk(port_if.empty_flag === 1'h1 && wr_ready === 1'h1, "after reset");
		conclude();
	end
endmodule : block_ram_fifo_reset_control_test
